// ---- hdl/pcp_defines.vh ----
// Register map, field positions and constants of the capture and PWM counter unit.
`ifndef PCP_DEFINES_VH
`define PCP_DEFINES_VH
`define PCP_ADR_CTRL_A 8'h00
`define PCP_ADR_CTRL_B 8'h04
`define PCP_ADR_CNT_L 8'h08
`define PCP_ADR_CNT_H 8'h0c
`define PCP_ADR_CMPA_L 8'h10
`define PCP_ADR_CMPA_H 8'h14
`define PCP_ADR_CMPB_L 8'h18
`define PCP_ADR_CMPB_H 8'h1c
`define PCP_ADR_CAP_L 8'h20
`define PCP_ADR_CAP_H 8'h24
`define PCP_ADR_IRQ_STAT 8'h28
`define PCP_ADR_IRQ_MASK 8'h2c
`define PCP_ACT_A_HI 7
`define PCP_ACT_A_LO 6
`define PCP_ACT_B_HI 5
`define PCP_ACT_B_LO 4
`define PCP_EDGE_BIT 6
`define PCP_CS_HI 2
`define PCP_CS_LO 0
`define PCP_GIE_BIT 7
`define PCP_IRQ_OVF 0
`define PCP_IRQ_CMPA 1
`define PCP_IRQ_CMPB 2
`define PCP_IRQ_CAP 3
`define PCP_CS_STOP 3'h0
`define PCP_CS_DIV1 3'h1
`define PCP_CS_DIV8 3'h2
`define PCP_CS_DIV64 3'h3
`define PCP_CS_DIV256 3'h4
`define PCP_CS_DIV1024 3'h5
`define PCP_CS_EXT_FALL 3'h6
`define PCP_CS_EXT_RISE 3'h7
`define PCP_MODE_OFF 2'h0
`define PCP_MODE_8 2'h1
`define PCP_MODE_9 2'h2
`define PCP_TOP_8 10'h0ff
`define PCP_TOP_9 10'h1ff
`define PCP_TOP_10 10'h3ff
`define PCP_PRE_7 10'h007
`define PCP_PRE_63 10'h03f
`define PCP_PRE_255 10'h0ff
`define PCP_PRE_1023 10'h3ff
`define PCP_CNT_MAX 16'hffff
`define PCP_ZERO16 16'h0000
`define PCP_ZERO10 10'h000
`endif

// ---- hdl/pcp_timer.v ----
// Sixteen-bit counter with pin capture and dual phase-correct PWM behind a Wishbone slave.
//
// Contract
// [R1] Selected capture edge copies counter into capture register and sets capture flag.
// [R2] Capture low read returns low byte and loads high byte into staging latch.
// [R3] One shared staging latch serves counter, both compares and capture.
// [R4] PWM mode gives two glitch-free phase-correct channels of 8, 9 or 10 bits.
// [R5] PWM counter counts up from zero to top, then down to zero, repeating.
// [R6] Top is 255, 511 or 1023 for 8, 9 or 10 bit resolution.
// [R7] Match when counter equals ten low compare bits; pin set or cleared by action.
// [R8] Action 0x unconnected; 10 clear up set down; 11 the opposite.
// [R9] PWM compare writes go to a buffer loaded into active value at top.
// [R10] Compare reads return the buffered, most recently written value.
// [R11] Compare zero or top settles output at next match per action table.
// [R12] Compare at top: undivided clock gives no pulse; divided gives one-period pulse.
// [R13] In PWM mode overflow flag sets when counter advances away from zero.
// [R14] Flags request interrupt when flag, own enable and global enable are set.
// [R15] Edge select zero captures falling edge; one captures rising edge.
// [R16] Clock select: stop, clock, divided by 8/64/256/1024, count pin falling/rising.
// [R17] Compare high byte is staged; low byte write updates all sixteen bits.
// [R18] PWM mode is an input; otherwise count up and compare writes act at once.
//
// Implementation choices: the register offsets and the Wishbone interface to the registers.
`include "pcp_defines.vh"
`timescale 1ns/1ps
`default_nettype none

module pcp_timer (
    // Clock and reset.
    input wire clk_i,
    input wire rst_i,
    // Wishbone slave.
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire wb_we_i,
    input wire [7:0] wb_adr_i,
    input wire [31:0] wb_dat_i,
    input wire [3:0] wb_sel_i,
    output reg [31:0] wb_dat_o,
    output wire wb_ack_o,
    // Configuration.
    input wire [1:0] pwm_mode_i,
    // Pins.
    input wire capture_pin_i,
    input wire count_pin_i,
    output wire pwm_out_a_o,
    output wire pwm_out_b_o,
    output wire pwm_conn_a_o,
    output wire pwm_conn_b_o,
    // Interrupt.
    output wire irq_o
);

    // ****************************************
    // Functions
    // ****************************************

    // Three-stage pin filter: the stable level follows once stages two and three agree.
    function filt;
        input s2;
        input s3;
        input cur;
        begin
            filt = (s2 == s3) ? s3 : cur;
        end
    endfunction

    // One PWM channel on arrival of the counter: returns {pending, output}.
    function [1:0] ch_step;
        input o;
        input p;
        input inv;
        input up;
        input undiv;
        input [9:0] c;
        input [9:0] v;
        input [9:0] top;
        begin
            if (c != v) begin
                ch_step = {p, o};
            end else if (v == top) begin
                if (undiv) begin
                    ch_step = {1'b0, ~inv}; // [R12] [R11]
                end else begin
                    ch_step = {~p, p ? inv : ~inv}; // [R12]
                end
            end else if (v == `PCP_ZERO10) begin
                ch_step = {p, inv}; // [R11]
            end else begin
                ch_step = {p, up ? inv : ~inv}; // [R7] [R8]
            end
        end
    endfunction

    // ****************************************
    // State
    // ****************************************

    reg ack_ff;
    reg [7:0] ctrl_a_ff;
    reg [7:0] ctrl_b_ff;
    reg [7:0] temp_ff;
    reg [15:0] cnt_ff;
    reg dir_dn_ff;
    reg [15:0] cmpa_buf_ff;
    reg [15:0] cmpb_buf_ff;
    reg [15:0] cmpa_ff;
    reg [15:0] cmpb_ff;
    reg [15:0] cap_ff;
    reg [3:0] stat_ff;
    reg [7:0] mask_ff;
    reg [9:0] pre_ff;
    reg [2:0] cpin_ff;
    reg cpin_lvl_ff;
    reg [2:0] tpin_ff;
    reg tpin_lvl_ff;
    reg out_a_ff;
    reg out_b_ff;
    reg pend_a_ff;
    reg pend_b_ff;

    wire acc = wb_cyc_i & wb_stb_i & ~ack_ff;
    wire wr = acc & wb_we_i & wb_sel_i[0];
    wire rd = acc & ~wb_we_i;
    wire [7:0] wd = wb_dat_i[7:0];
    wire pwm = (pwm_mode_i != `PCP_MODE_OFF);
    wire [2:0] cs = ctrl_b_ff[`PCP_CS_HI:`PCP_CS_LO];
    wire [1:0] act_a = ctrl_a_ff[`PCP_ACT_A_HI:`PCP_ACT_A_LO];
    wire [1:0] act_b = ctrl_a_ff[`PCP_ACT_B_HI:`PCP_ACT_B_LO];

    // ****************************************
    // Prescaler and clock select
    // ****************************************

    wire cpin_nxt = filt(cpin_ff[1], cpin_ff[2], cpin_lvl_ff);
    wire tpin_nxt = filt(tpin_ff[1], tpin_ff[2], tpin_lvl_ff);
    reg tick;

    always @* begin
        case (cs) // [R16]
            `PCP_CS_DIV1: tick = 1'b1;
            `PCP_CS_DIV8: tick = (pre_ff[2:0] == `PCP_PRE_7);
            `PCP_CS_DIV64: tick = (pre_ff[5:0] == `PCP_PRE_63);
            `PCP_CS_DIV256: tick = (pre_ff[7:0] == `PCP_PRE_255);
            `PCP_CS_DIV1024: tick = (pre_ff == `PCP_PRE_1023);
            `PCP_CS_EXT_FALL: tick = tpin_lvl_ff & ~tpin_nxt;
            `PCP_CS_EXT_RISE: tick = ~tpin_lvl_ff & tpin_nxt;
            default: tick = 1'b0;
        endcase
    end

    // ****************************************
    // Counter next value
    // ****************************************

    reg [9:0] top;
    reg [15:0] nxt_cnt;
    reg nxt_dir_dn;
    reg cnt_wr;

    always @* begin
        case (pwm_mode_i) // [R6]
            `PCP_MODE_8: top = `PCP_TOP_8;
            `PCP_MODE_9: top = `PCP_TOP_9;
            default: top = `PCP_TOP_10;
        endcase
    end

    always @* begin
        nxt_cnt = cnt_ff;
        nxt_dir_dn = dir_dn_ff;
        if (!pwm) begin
            nxt_cnt = cnt_ff + 16'h0001; // [R18]
            nxt_dir_dn = 1'b0;
        end else if (!dir_dn_ff) begin
            if (cnt_ff[9:0] >= top) begin
                nxt_cnt = cnt_ff - 16'h0001; // [R5]
                nxt_dir_dn = 1'b1;
            end else begin
                nxt_cnt = cnt_ff + 16'h0001;
            end
        end else begin
            if (cnt_ff == `PCP_ZERO16) begin
                nxt_cnt = cnt_ff + 16'h0001; // [R5]
                nxt_dir_dn = 1'b0;
            end else begin
                nxt_cnt = cnt_ff - 16'h0001;
            end
        end
    end

    wire adv = tick & ~cnt_wr;
    // The direction is that of the step onto the new count, so a turn at top or zero counts right.
    wire up_mv = ~nxt_dir_dn; // [R8]
    wire at_top = pwm & adv & ~nxt_dir_dn & (nxt_cnt[9:0] == top);
    wire ovf = adv & (pwm ? (cnt_ff == `PCP_ZERO16) : (cnt_ff == `PCP_CNT_MAX)); // [R13]
    wire hit_a = adv & (pwm ? (nxt_cnt[9:0] == cmpa_ff[9:0]) : (nxt_cnt == cmpa_ff)); // [R7]
    wire hit_b = adv & (pwm ? (nxt_cnt[9:0] == cmpb_ff[9:0]) : (nxt_cnt == cmpb_ff));
    wire undiv = (cs == `PCP_CS_DIV1);
    wire [1:0] st_a = ch_step(out_a_ff, pend_a_ff, act_a[0], up_mv, undiv,
                              nxt_cnt[9:0], cmpa_ff[9:0], top);
    wire [1:0] st_b = ch_step(out_b_ff, pend_b_ff, act_b[0], up_mv, undiv,
                              nxt_cnt[9:0], cmpb_ff[9:0], top);
    wire cap_ev = ctrl_b_ff[`PCP_EDGE_BIT] ? (~cpin_lvl_ff & cpin_nxt)
                                           : (cpin_lvl_ff & ~cpin_nxt); // [R15]

    // ****************************************
    // Read data multiplexer
    // ****************************************

    reg [7:0] rdat;

    always @* begin
        if (wb_adr_i == `PCP_ADR_CTRL_A) begin
            rdat = ctrl_a_ff;
        end else if (wb_adr_i == `PCP_ADR_CTRL_B) begin
            rdat = ctrl_b_ff;
        end else if (wb_adr_i == `PCP_ADR_CNT_L) begin
            rdat = cnt_ff[7:0];
        end else if (wb_adr_i == `PCP_ADR_CMPA_L) begin
            rdat = cmpa_buf_ff[7:0]; // [R10]
        end else if (wb_adr_i == `PCP_ADR_CMPB_L) begin
            rdat = cmpb_buf_ff[7:0]; // [R10]
        end else if (wb_adr_i == `PCP_ADR_CAP_L) begin
            rdat = cap_ff[7:0]; // [R2]
        end else if ((wb_adr_i == `PCP_ADR_CNT_H) || (wb_adr_i == `PCP_ADR_CMPA_H) ||
                     (wb_adr_i == `PCP_ADR_CMPB_H) || (wb_adr_i == `PCP_ADR_CAP_H)) begin
            rdat = temp_ff; // [R2] [R3]
        end else if (wb_adr_i == `PCP_ADR_IRQ_STAT) begin
            rdat = {4'h0, stat_ff};
        end else if (wb_adr_i == `PCP_ADR_IRQ_MASK) begin
            rdat = mask_ff;
        end else begin
            rdat = 8'h00;
        end
    end

    // ****************************************
    // Bus side registers
    // ****************************************

    always @(posedge clk_i) begin
        if (rst_i) begin
            ack_ff <= 1'b0;
            wb_dat_o <= 32'h00000000;
            ctrl_a_ff <= 8'h00;
            ctrl_b_ff <= 8'h00;
            temp_ff <= 8'h00;
            mask_ff <= 8'h00;
        end else begin
            ack_ff <= acc;
            if (rd) begin
                wb_dat_o <= {24'h000000, rdat};
            end
            if (rd && wb_adr_i == `PCP_ADR_CNT_L) begin
                temp_ff <= cnt_ff[15:8]; // [R3]
            end else if (rd && wb_adr_i == `PCP_ADR_CMPA_L) begin
                temp_ff <= cmpa_buf_ff[15:8]; // [R3]
            end else if (rd && wb_adr_i == `PCP_ADR_CMPB_L) begin
                temp_ff <= cmpb_buf_ff[15:8]; // [R3]
            end else if (rd && wb_adr_i == `PCP_ADR_CAP_L) begin
                temp_ff <= cap_ff[15:8]; // [R2]
            end else if (wr && ((wb_adr_i == `PCP_ADR_CNT_H) ||
                                (wb_adr_i == `PCP_ADR_CMPA_H) ||
                                (wb_adr_i == `PCP_ADR_CMPB_H))) begin
                temp_ff <= wd; // [R17] [R3]
            end
            if (wr && wb_adr_i == `PCP_ADR_CTRL_A) begin
                ctrl_a_ff <= wd;
            end
            if (wr && wb_adr_i == `PCP_ADR_CTRL_B) begin
                ctrl_b_ff <= wd;
            end
            if (wr && wb_adr_i == `PCP_ADR_IRQ_MASK) begin
                mask_ff <= wd;
            end
        end
    end

    always @* begin
        cnt_wr = wr && (wb_adr_i == `PCP_ADR_CNT_L);
    end

    // ****************************************
    // Counter, compare and capture
    // ****************************************

    // A counter write wins over a count edge in the same cycle.
    always @(posedge clk_i) begin
        if (rst_i) begin
            cnt_ff <= `PCP_ZERO16;
            dir_dn_ff <= 1'b0;
            cmpa_buf_ff <= `PCP_ZERO16;
            cmpb_buf_ff <= `PCP_ZERO16;
            cmpa_ff <= `PCP_ZERO16;
            cmpb_ff <= `PCP_ZERO16;
            cap_ff <= `PCP_ZERO16;
            pre_ff <= `PCP_ZERO10;
        end else begin
            pre_ff <= pre_ff + 10'h001;
            if (cnt_wr) begin
                cnt_ff <= {temp_ff, wd};
            end else if (tick) begin
                cnt_ff <= nxt_cnt;
                dir_dn_ff <= nxt_dir_dn;
            end
            if (!pwm) begin
                dir_dn_ff <= 1'b0;
            end
            if (wr && wb_adr_i == `PCP_ADR_CMPA_L) begin
                cmpa_buf_ff <= {temp_ff, wd}; // [R17] [R9]
                if (!pwm) begin
                    cmpa_ff <= {temp_ff, wd}; // [R18]
                end else begin
                    cmpa_ff[15:10] <= temp_ff[7:2];
                end
            end else if (at_top) begin
                cmpa_ff[9:0] <= cmpa_buf_ff[9:0]; // [R9]
            end
            if (wr && wb_adr_i == `PCP_ADR_CMPB_L) begin
                cmpb_buf_ff <= {temp_ff, wd}; // [R17] [R9]
                if (!pwm) begin
                    cmpb_ff <= {temp_ff, wd}; // [R18]
                end else begin
                    cmpb_ff[15:10] <= temp_ff[7:2];
                end
            end else if (at_top) begin
                cmpb_ff[9:0] <= cmpb_buf_ff[9:0]; // [R9]
            end
            if (cap_ev) begin
                cap_ff <= cnt_ff; // [R1]
            end
        end
    end

    // ****************************************
    // Pin filters and PWM outputs
    // ****************************************

    always @(posedge clk_i) begin
        if (rst_i) begin
            cpin_ff <= 3'h0;
            cpin_lvl_ff <= 1'b0;
            tpin_ff <= 3'h0;
            tpin_lvl_ff <= 1'b0;
            out_a_ff <= 1'b0;
            out_b_ff <= 1'b0;
            pend_a_ff <= 1'b0;
            pend_b_ff <= 1'b0;
        end else begin
            cpin_ff <= {cpin_ff[1:0], capture_pin_i};
            cpin_lvl_ff <= cpin_nxt;
            tpin_ff <= {tpin_ff[1:0], count_pin_i};
            tpin_lvl_ff <= tpin_nxt;
            if (pwm && adv) begin
                {pend_a_ff, out_a_ff} <= st_a; // [R4] [R7]
                {pend_b_ff, out_b_ff} <= st_b; // [R4] [R7]
            end
        end
    end

    assign pwm_conn_a_o = pwm & act_a[1]; // [R8]
    assign pwm_conn_b_o = pwm & act_b[1]; // [R8]
    assign pwm_out_a_o = pwm_conn_a_o & out_a_ff;
    assign pwm_out_b_o = pwm_conn_b_o & out_b_ff;

    // ****************************************
    // Interrupt status
    // ****************************************

    // A hardware set in the same cycle as a write-one clear keeps the flag set.
    wire [3:0] ev = {cap_ev, hit_b, hit_a, ovf};
    wire [3:0] clr = (wr && wb_adr_i == `PCP_ADR_IRQ_STAT) ? wd[3:0] : 4'h0;

    always @(posedge clk_i) begin
        if (rst_i) begin
            stat_ff <= 4'h0;
        end else begin
            stat_ff <= (stat_ff & ~clr) | ev; // [R1] [R13]
        end
    end

    assign irq_o = mask_ff[`PCP_GIE_BIT] & |(stat_ff & mask_ff[3:0]); // [R14]
    assign wb_ack_o = ack_ff;

endmodule // pcp_timer

`default_nettype wire

// ---- verif/pcp_timer_monitor.sv ----
// Checker of the bus, interrupt and PWM pin behaviour of the counter unit.
`timescale 1ns/1ps
`default_nettype none
module pcp_timer_monitor (
    // Clock and reset.
    input wire logic clk_i,
    input wire logic rst_i,
    // Bus.
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    // Pins and interrupt.
    input wire logic [1:0] pwm_mode_i,
    input wire logic pwm_out_a_o,
    input wire logic pwm_out_b_o,
    input wire logic pwm_conn_a_o,
    input wire logic pwm_conn_b_o,
    input wire logic irq_o
);
    // ****
    // Properties.
    // ****
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    property p_ack_pulse; wb_ack_o |=> !wb_ack_o; endproperty
    a_ack_pulse: assert property (p_ack_pulse) else $error("ack too long");
    property p_ack_ans; wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o; endproperty
    a_ack_ans: assert property (p_ack_ans) else $error("no ack");
    property p_dat_hi; wb_ack_o |-> wb_dat_o[31:8] == 24'h000000; endproperty
    a_dat_hi: assert property (p_dat_hi) else $error("upper read bits set");
    property p_unmap; wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_we_i && wb_adr_i == 8'h30
        |=> wb_dat_o == 32'h00000000; endproperty
    a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
    property p_gate; !pwm_conn_a_o && !pwm_conn_b_o |-> !pwm_out_a_o && !pwm_out_b_o; endproperty
    a_gate: assert property (p_gate) else $error("pin level while off");
    property p_idle; pwm_mode_i == 2'h0 && $past(pwm_mode_i, 2) == 2'h0
        |-> !pwm_conn_a_o && !pwm_conn_b_o; endproperty
    a_idle: assert property (p_idle) else $error("pin on in normal mode");
    property p_glitch; $changed(pwm_out_a_o) && pwm_conn_a_o && $past(pwm_conn_a_o)
        |=> $stable(pwm_out_a_o); endproperty
    a_glitch: assert property (p_glitch) else $error("pwm glitch");
    property p_gie; wb_cyc_i && wb_stb_i && !wb_ack_o && wb_we_i && wb_sel_i[0]
        && wb_adr_i == 8'h2c && !wb_dat_i[7] |-> ##2 !irq_o; endproperty
    a_gie: assert property (p_gie) else $error("irq without global enable");
endmodule // pcp_timer_monitor
bind pcp_timer pcp_timer_monitor pcp_timer_monitor_i (.clk_i(clk_i), .rst_i(rst_i),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_dat_i(wb_dat_i), .wb_sel_i(wb_sel_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .pwm_mode_i(pwm_mode_i), .pwm_out_a_o(pwm_out_a_o), .pwm_out_b_o(pwm_out_b_o),
    .pwm_conn_a_o(pwm_conn_a_o), .pwm_conn_b_o(pwm_conn_b_o), .irq_o(irq_o));
`default_nettype wire

// ---- verif/pcp_partner.sv ----
// Far side: capture source, count pin source and a meter on the PWM load.
`timescale 1ns/1ps
`default_nettype none
module pcp_partner (
    // Clock and command.
    input wire logic clk_i,
    input wire logic cap_lvl_i,
    // Pins of the unit.
    input wire logic pwm_a_i,
    output logic capture_pin_o = 1'b0,
    output logic count_pin_o = 1'b0,
    // Measured period and high time of the load.
    output logic [15:0] period_o = 16'h0000,
    output logic [15:0] high_o = 16'h0000
);
    // ****
    // Pin sources and load meter.
    // ****
    logic [15:0] run_ff = 16'h0000;
    logic [2:0] div_ff = 3'h0;
    logic last_ff = 1'b0;
    always @(posedge clk_i) begin
        capture_pin_o <= cap_lvl_i;
        div_ff <= div_ff + 3'h1;
        if (div_ff == 3'h7) begin
            count_pin_o <= ~count_pin_o;
        end
        last_ff <= pwm_a_i;
        run_ff <= run_ff + 16'h0001;
        if (pwm_a_i && !last_ff) begin
            period_o <= run_ff + 16'h0001;
            run_ff <= 16'h0000;
        end
        if (!pwm_a_i && last_ff) begin
            high_o <= run_ff + 16'h0001;
        end
    end
endmodule // pcp_partner
`default_nettype wire

// ---- verif/pcp_timer_bench.sv ----
// Self-checking bench of the capture and PWM counter unit.
`timescale 1ns/1ps
`default_nettype none
module pcp_timer_bench;
    // ****
    // Stimulus, checks and scenarios.
    // ****
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic cyc = 1'b0;
    logic we = 1'b0;
    logic cap = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [7:0] wd = 8'h00;
    logic [1:0] mode = 2'h0;
    logic [31:0] rd;
    logic [15:0] v;
    wire logic ack, pa, pb, ca, cb, irq, cpin, kpin;
    wire logic [31:0] dat;
    wire logic [15:0] per, hi;
    int errors = 0;
    int checks_done = 0;
    pcp_timer pcp_timer_i (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(cyc),
        .wb_we_i(we), .wb_adr_i(adr), .wb_dat_i({24'h000000, wd}), .wb_sel_i(4'h1),
        .wb_dat_o(dat), .wb_ack_o(ack), .pwm_mode_i(mode), .capture_pin_i(cpin),
        .count_pin_i(kpin), .pwm_out_a_o(pa), .pwm_out_b_o(pb), .pwm_conn_a_o(ca),
        .pwm_conn_b_o(cb), .irq_o(irq));
    pcp_partner pcp_partner_i (.clk_i(clk_i), .cap_lvl_i(cap), .pwm_a_i(pa),
        .capture_pin_o(cpin), .count_pin_o(kpin), .period_o(per), .high_o(hi));
    initial forever #2.5 clk_i = ~clk_i;
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp) begin
            errors++;
            $display("Error %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d);
        int n;
        n = 0;
        cyc <= 1'b1;
        we <= w;
        adr <= a;
        wd <= d;
        do begin
            @(posedge clk_i);
            n++;
        end while (ack !== 1'b1 && n < 40);
        if (n >= 40) begin
            errors++;
            wrap_up();
        end
        rd = dat;
        cyc <= 1'b0;
        @(posedge clk_i);
    endtask
    task automatic rd16(input logic [7:0] a);
        wb(1'b0, a, 8'h00);
        v[7:0] = rd[7:0];
        wb(1'b0, a + 8'h04, 8'h00);
        v[15:8] = rd[7:0];
    endtask
    task automatic wr16(input logic [7:0] a, input logic [15:0] d);
        wb(1'b1, a + 8'h04, d[15:8]);
        wb(1'b1, a, d[7:0]);
    endtask
    task automatic pin(input logic lvl);
        cap <= lvl;
        repeat (8) @(posedge clk_i);
    endtask
    task automatic t_reset;
        rd16(8'h20);
        chk("cap_rst", v, 16'h0000);
        wb(1'b1, 8'h20, 8'h5a);
        rd16(8'h20);
        chk("cap_ro", v, 16'h0000);
        wb(1'b0, 8'h30, 8'h00);
        chk("unmapped", rd[15:0], 16'h0000);
        $display("t_reset done");
    endtask
    task automatic t_rate;
        logic [15:0] e [8];
        e = '{16'd0, 16'd2051, 16'd256, 16'd32, 16'd8, 16'd2, 16'd128, 16'd128};
        for (int cs = 0; cs < 8; cs++) begin
            wb(1'b1, 8'h04, 8'(cs));
            wr16(8'h08, 16'h0000);
            repeat (2048) @(posedge clk_i);
            rd16(8'h08);
            chk("rate", 16'(v + 16'd3 >= e[cs] && v <= e[cs] + 16'd3), 16'h0001);
        end
        $display("t_rate done");
    endtask
    task automatic t_capture;
        wb(1'b1, 8'h04, 8'h40);
        wb(1'b1, 8'h2c, 8'h88);
        wr16(8'h08, 16'h1234);
        pin(1'b1);
        chk("irq_cap", 16'(irq), 16'h0001);
        rd16(8'h20);
        chk("cap_rise", v, 16'h1234);
        wr16(8'h08, 16'h5678);
        pin(1'b0);
        rd16(8'h20);
        chk("cap_fall_off", v, 16'h1234);
        wb(1'b1, 8'h04, 8'h00);
        pin(1'b1);
        pin(1'b0);
        rd16(8'h20);
        chk("cap_fall", v, 16'h5678);
        wr16(8'h08, 16'h9abc);
        wb(1'b0, 8'h20, 8'h00);
        wb(1'b0, 8'h08, 8'h00);
        wb(1'b0, 8'h24, 8'h00);
        chk("latch", rd[15:0], 16'h009a);
        wb(1'b1, 8'h2c, 8'h08);
        chk("irq_gie", 16'(irq), 16'h0000);
        wb(1'b1, 8'h2c, 8'h88);
        chk("irq_on", 16'(irq), 16'h0001);
        wb(1'b1, 8'h28, 8'h0f);
        wb(1'b0, 8'h28, 8'h00);
        chk("stat_clr", rd[15:0] | 16'(irq), 16'h0000);
        $display("t_capture done");
    endtask
    task automatic t_pwm;
        wr16(8'h10, 16'h0040);
        wr16(8'h18, 16'h0040);
        wr16(8'h08, 16'h0000);
        wb(1'b1, 8'h00, 8'hb0);
        wb(1'b1, 8'h04, 8'h01);
        for (int m = 1; m < 4; m++) begin
            mode <= 2'(m);
            repeat (6138) @(posedge clk_i);
            chk("period", per, 16'((512 << (m - 1)) - 2));
            chk("high", hi, 16'd128);
            chk("inv", 16'({ca, cb, pa ^ pb}), 16'h0007);
        end
        wr16(8'h10, 16'h0080);
        rd16(8'h10);
        chk("cmp_read", v, 16'h0080);
        repeat (6138) @(posedge clk_i);
        chk("new_high", hi, 16'd256);
        mode <= 2'h1;
        wr16(8'h08, 16'h0000);
        wr16(8'h10, 16'h0000);
        wr16(8'h18, 16'h0000);
        wb(1'b1, 8'h28, 8'h0f);
        repeat (1100) @(posedge clk_i);
        wb(1'b0, 8'h28, 8'h00);
        chk("ovf", 16'(rd[0]), 16'h0001);
        chk("zero", 16'({pa, pb}), 16'h0001);
        wr16(8'h10, 16'h00ff);
        wr16(8'h18, 16'h00ff);
        repeat (1100) @(posedge clk_i);
        chk("top", 16'({pa, pb}), 16'h0002);
        wr16(8'h10, 16'h0001);
        repeat (2000) @(posedge clk_i);
        chk("turn_high", hi, 16'd2);
        chk("turn_period", per, 16'd510);
        wb(1'b1, 8'h04, 8'h02);
        wr16(8'h10, 16'h00ff);
        repeat (20000) @(posedge clk_i);
        chk("div_period", per, 16'd8160);
        chk("div_high", hi, 16'd4080);
        wb(1'b1, 8'h00, 8'h10);
        chk("codes_off", 16'({ca, cb, pa, pb}), 16'h0000);
        mode <= 2'h0;
        wb(1'b1, 8'h00, 8'hb0);
        chk("normal", 16'({ca, cb}), 16'h0000);
        $display("t_pwm done");
    endtask
    initial begin
        repeat (4) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        t_reset();
        t_rate();
        t_capture();
        t_pwm();
        wrap_up();
    end
endmodule // pcp_timer_bench
`default_nettype wire
